// File: verilog/pcs_pkg.sv
// constants, types and register map of the socket signal block
// assumes a single 50 MHz clock domain and a plain register port
// Overview of operation
// - first activity pin shows its socket's bus activity, second pin the other socket's
// - shared pins reset to general inputs
// - second pin change raises status-change interrupt
// - speaker is xor of both cards' audio
// - suspend keeps registers through host reset
// - 26-bit address, 16-bit data, msb highest
// - battery inputs decode good, weak, dead
// - first battery input is status change in io
// - card audio only taken in io interface
// - card inserted when both detects are low
// - first enable even bytes, second odd bytes
// - io read strobe for io reads, dma to host
// - io write strobe for io writes, dma to card
// - output enable for reads, count at dma write
// - write enable for writes, count at dma read
// - ready means busy/ready or interrupt request by mode
// - attribute select high for common memory only
// - attribute select is dma acknowledge with strobe
// - card reset output forces hard card reset
// - wait input stretches the running cycle
// - write-protect pin is wide port in io mode
package pcs_pkg;
  localparam int PCS_CLK_NS = 20;
  localparam int PCS_SETUP_NS = 60;
  localparam int PCS_STROBE_NS = 300;
  localparam int PCS_HOLD_NS = 40;
  localparam logic [4:0] PCS_SETUP_CYC = 5'((PCS_SETUP_NS + PCS_CLK_NS - 1) / PCS_CLK_NS);
  localparam logic [4:0] PCS_STROBE_CYC = 5'((PCS_STROBE_NS + PCS_CLK_NS - 1) / PCS_CLK_NS);
  localparam logic [4:0] PCS_HOLD_CYC = 5'((PCS_HOLD_NS + PCS_CLK_NS - 1) / PCS_CLK_NS);

  localparam logic [7:0] PCS_REG_CTRL = 8'h00;
  localparam logic [7:0] PCS_REG_ADDR = 8'h04;
  localparam logic [7:0] PCS_REG_WDATA = 8'h08;
  localparam logic [7:0] PCS_REG_CMD = 8'h0c;
  localparam logic [7:0] PCS_REG_RDATA = 8'h10;
  localparam logic [7:0] PCS_REG_STATUS = 8'h14;
  localparam logic [7:0] PCS_REG_CLEAR = 8'h18;

  // control register fields
  localparam int PCS_CTRL_IO = 0;
  localparam int PCS_CTRL_CRST = 1;
  localparam int PCS_CTRL_PIN0 = 2;
  localparam int PCS_CTRL_PIN1 = 4;
  localparam int PCS_CTRL_GPO = 6;
  localparam int PCS_CTRL_CHGEN = 8;
  localparam int PCS_CTRL_DSEL = 9;
  // command register fields
  localparam int PCS_CMD_KIND = 0;
  localparam int PCS_CMD_TCNT = 3;
  localparam int PCS_CMD_BE = 4;

  localparam logic [1:0] PCS_PIN_IN = 2'h0;
  localparam logic [1:0] PCS_PIN_OUT = 2'h1;
  localparam logic [1:0] PCS_PIN_LED = 2'h2;
  localparam logic [1:0] PCS_PIN_VIDEO = 2'h3;

  localparam logic [1:0] PCS_DREQ_BATT = 2'h0;
  localparam logic [1:0] PCS_DREQ_ACK = 2'h1;
  localparam logic [1:0] PCS_DREQ_PROT = 2'h2;

  localparam logic [2:0] PCS_K_MEM_RD = 3'h0;
  localparam logic [2:0] PCS_K_MEM_WR = 3'h1;
  localparam logic [2:0] PCS_K_ATTR_RD = 3'h2;
  localparam logic [2:0] PCS_K_ATTR_WR = 3'h3;
  localparam logic [2:0] PCS_K_IO_RD = 3'h4;
  localparam logic [2:0] PCS_K_IO_WR = 3'h5;
  localparam logic [2:0] PCS_K_DMA_IN = 3'h6;
  localparam logic [2:0] PCS_K_DMA_OUT = 3'h7;

  localparam logic [1:0] PCS_BATT_GOOD = 2'h0;
  localparam logic [1:0] PCS_BATT_WEAK = 2'h1;
  localparam logic [1:0] PCS_BATT_DEAD = 2'h2;

  typedef enum logic [1:0] {PCS_IDLE, PCS_SETUP, PCS_STROBE, PCS_HOLD} pcs_phase_t;

  typedef struct packed {
    pcs_phase_t phase;
    logic [4:0] cnt;
    logic io_mode;
    logic card_reset;
    logic [1:0] pin0_mode;
    logic [1:0] pin1_mode;
    logic [1:0] gpo;
    logic chg_en;
    logic [1:0] dma_sel;
    logic [25:0] addr;
    logic [15:0] wdata;
    logic [2:0] kind;
    logic term_count;
    logic [1:0] be;
    logic [15:0] card_rdata;
    logic ack;
    logic chg_flag;
    logic gp1_prev;
    logic speaker;
    logic [31:0] rdata;
  } pcs_state_t;

  localparam pcs_state_t PCS_STATE_RST = '0;
endpackage

// File: verilog/pcs_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes an async active-low reset and a clock enable
`timescale 1ns/100ps
module pcs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else if (ce) begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // pcs_sync

// File: verilog/pcs_socket.sv
// one 16-bit card socket: cycle sequencer, pin sensing, shared pins
// assumes the other socket supplies its activity and audio on this clock
`timescale 1ns/100ps
module pcs_socket (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WSTB,
  input wire logic RSTB,
  output logic [31:0] RDATA,
  output logic [25:0] CARD_ADDRESS,
  input wire logic [15:0] CARD_DATA_IN,
  output logic [15:0] CARD_DATA_OUT,
  output logic CARD_DATA_OE_N,
  output logic EVEN_BYTE_CARD_ENABLE_N,
  output logic ODD_BYTE_CARD_ENABLE_N,
  output logic OUTPUT_ENABLE_N,
  output logic WRITE_ENABLE_N,
  output logic IO_READ_STROBE_N,
  output logic IO_WRITE_STROBE_N,
  output logic ATTRIBUTE_SELECT_N,
  output logic CARD_RESET,
  input wire logic CARD_DETECT_FIRST_N,
  input wire logic CARD_DETECT_SECOND_N,
  input wire logic BATTERY_DETECT_FIRST,
  input wire logic BATTERY_DETECT_SECOND,
  input wire logic CARD_READY,
  input wire logic WAIT_N,
  input wire logic WRITE_PROTECT,
  input wire logic INPUT_ACKNOWLEDGE_N,
  input wire logic VOLTAGE_SENSE_FIRST,
  input wire logic VOLTAGE_SENSE_SECOND,
  input wire logic GENERAL_PIN_0_IN,
  output logic GENERAL_PIN_0_OUT,
  output logic GENERAL_PIN_0_OE_N,
  input wire logic GENERAL_PIN_1_IN,
  output logic GENERAL_PIN_1_OUT,
  output logic GENERAL_PIN_1_OE_N,
  input wire logic VIDEO_PORT_ENABLE_STATUS,
  input wire logic SUSPEND_N,
  input wire logic OTHER_SOCKET_ACTIVITY,
  input wire logic OTHER_SOCKET_AUDIO,
  output logic SOCKET_ACTIVITY,
  output logic CARD_BINARY_AUDIO,
  output logic HOST_SPEAKER_OUT,
  output logic CARD_STATUS_CHANGE_INTERRUPT,
  output logic DMA_REQUEST
);
  localparam int SYNC_W = 28;

  logic rst_n;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins;
  logic cd1_n;
  logic cd2_n;
  logic batt1;
  logic batt2;
  logic ready;
  logic wait_n;
  logic wprot;
  logic inack_n;
  logic vs1;
  logic vs2;
  logic gp0_in;
  logic gp1_in;
  logic suspend;
  logic [15:0] data_in;
  logic card_inserted;
  logic [1:0] batt_state;
  logic wait_active;
  logic card_audio;
  logic dma_req;
  logic active;
  logic in_strobe;
  logic dma_cycle;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  pcs_pkg::pcs_state_t s;
  pcs_pkg::pcs_state_t next_s;

  // reset release through two flops
  pcs_sync #(.W(1)) u_rst_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(1'b1),
    .din(1'b1),
    .dout(rst_n)
  );

  assign pins_raw = {CARD_DATA_IN, GENERAL_PIN_1_IN, GENERAL_PIN_0_IN,
                     VOLTAGE_SENSE_SECOND, VOLTAGE_SENSE_FIRST, INPUT_ACKNOWLEDGE_N,
                     WRITE_PROTECT, WAIT_N, CARD_READY, BATTERY_DETECT_SECOND,
                     BATTERY_DETECT_FIRST, CARD_DETECT_SECOND_N, CARD_DETECT_FIRST_N};

  pcs_sync #(.W(SYNC_W)) u_pin_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .din(pins_raw),
    .dout(pins)
  );

  // suspend kept out of the host reset so it can guard the registers
  pcs_sync #(.W(1)) u_susp_sync (
    .clk(CLK),
    .rst_n(1'b1),
    .ce(CE),
    .din(~SUSPEND_N),
    .dout(suspend)
  );

  assign cd1_n = pins[0];
  assign cd2_n = pins[1];
  assign batt1 = pins[2];
  assign batt2 = pins[3];
  assign ready = pins[4];
  assign wait_n = pins[5];
  assign wprot = pins[6];
  assign inack_n = pins[7];
  assign vs1 = pins[8];
  assign vs2 = pins[9];
  assign gp0_in = pins[10];
  assign gp1_in = pins[11];
  assign data_in = pins[27:12];

  // pin sensing
  assign card_inserted = !cd1_n && !cd2_n;
  assign batt_state = !batt1 ? pcs_pkg::PCS_BATT_DEAD :
                      (!batt2 ? pcs_pkg::PCS_BATT_WEAK : pcs_pkg::PCS_BATT_GOOD);
  assign wait_active = !wait_n;
  assign card_audio = s.io_mode && batt2;
  always_comb begin
    case (s.dma_sel)
      pcs_pkg::PCS_DREQ_BATT: dma_req = batt2;
      pcs_pkg::PCS_DREQ_ACK: dma_req = !inack_n;
      pcs_pkg::PCS_DREQ_PROT: dma_req = wprot;
      default: dma_req = 1'b0;
    endcase
  end

  assign active = s.phase != pcs_pkg::PCS_IDLE;
  assign in_strobe = s.phase == pcs_pkg::PCS_STROBE;
  assign dma_cycle = s.kind[2] && s.kind[1];

  assign status_word = {17'h00000, gp1_in, gp0_in, vs2, vs1, dma_req, s.chg_flag, s.ack,
                        wprot, ready && s.io_mode, ready && !s.io_mode,
                        batt1 && s.io_mode, batt_state, card_inserted, active};
  assign ctrl_word = {21'h000000, s.dma_sel, s.chg_en, s.gpo, s.pin1_mode, s.pin0_mode,
                      s.card_reset, s.io_mode};

  always_comb begin
    next_s = s;
    // register writes
    if (WSTB) begin
      case (ADDR)
        pcs_pkg::PCS_REG_CTRL: begin
          next_s.io_mode = WDATA[pcs_pkg::PCS_CTRL_IO];
          next_s.card_reset = WDATA[pcs_pkg::PCS_CTRL_CRST];
          next_s.pin0_mode = WDATA[pcs_pkg::PCS_CTRL_PIN0 +: 2];
          next_s.pin1_mode = WDATA[pcs_pkg::PCS_CTRL_PIN1 +: 2];
          next_s.gpo = WDATA[pcs_pkg::PCS_CTRL_GPO +: 2];
          next_s.chg_en = WDATA[pcs_pkg::PCS_CTRL_CHGEN];
          next_s.dma_sel = WDATA[pcs_pkg::PCS_CTRL_DSEL +: 2];
        end
        pcs_pkg::PCS_REG_ADDR: begin
          next_s.addr = WDATA[25:0];
        end
        pcs_pkg::PCS_REG_WDATA: begin
          next_s.wdata = WDATA[15:0];
        end
        pcs_pkg::PCS_REG_CMD: begin
          if (!active) begin
            next_s.kind = WDATA[pcs_pkg::PCS_CMD_KIND +: 3];
            next_s.term_count = WDATA[pcs_pkg::PCS_CMD_TCNT];
            next_s.be = WDATA[pcs_pkg::PCS_CMD_BE +: 2];
            next_s.phase = pcs_pkg::PCS_SETUP;
            next_s.cnt = pcs_pkg::PCS_SETUP_CYC - 5'h01;
          end
        end
        pcs_pkg::PCS_REG_CLEAR: begin
          if (WDATA[0]) begin
            next_s.chg_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // register reads, answer in the next cycle
    next_s.rdata = 32'h00000000;
    if (RSTB) begin
      case (ADDR)
        pcs_pkg::PCS_REG_CTRL: next_s.rdata = ctrl_word;
        pcs_pkg::PCS_REG_ADDR: next_s.rdata = {6'h00, s.addr};
        pcs_pkg::PCS_REG_WDATA: next_s.rdata = {16'h0000, s.wdata};
        pcs_pkg::PCS_REG_CMD: next_s.rdata = {26'h0000000, s.be, s.term_count, s.kind};
        pcs_pkg::PCS_REG_RDATA: next_s.rdata = {16'h0000, s.card_rdata};
        pcs_pkg::PCS_REG_STATUS: next_s.rdata = status_word;
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    // cycle sequencer
    case (s.phase)
      pcs_pkg::PCS_IDLE: begin
      end
      pcs_pkg::PCS_SETUP: begin
        if (s.cnt == 5'h00) begin
          next_s.phase = pcs_pkg::PCS_STROBE;
          next_s.cnt = pcs_pkg::PCS_STROBE_CYC - 5'h01;
        end else begin
          next_s.cnt = s.cnt - 5'h01;
        end
      end
      pcs_pkg::PCS_STROBE: begin
        if (s.cnt != 5'h00) begin
          next_s.cnt = s.cnt - 5'h01;
        end else if (!wait_active) begin
          if (!s.kind[0]) begin
            next_s.card_rdata = data_in;
            next_s.ack = !inack_n;
          end
          next_s.phase = pcs_pkg::PCS_HOLD;
          next_s.cnt = pcs_pkg::PCS_HOLD_CYC - 5'h01;
        end
      end
      pcs_pkg::PCS_HOLD: begin
        if (s.cnt == 5'h00) begin
          next_s.phase = pcs_pkg::PCS_IDLE;
        end else begin
          next_s.cnt = s.cnt - 5'h01;
        end
      end
      default: begin
        next_s.phase = pcs_pkg::PCS_IDLE;
      end
    endcase
    // change on the second general pin, set beats clear
    next_s.gp1_prev = gp1_in;
    if (s.chg_en && (gp1_in != s.gp1_prev)) begin
      next_s.chg_flag = 1'b1;
    end
    next_s.speaker = card_audio ^ OTHER_SOCKET_AUDIO;
    // host reset: suspend keeps the register contents
    if (!rst_n) begin
      if (!suspend) begin
        next_s = pcs_pkg::PCS_STATE_RST;
      end else begin
        next_s.phase = pcs_pkg::PCS_IDLE;
        next_s.cnt = 5'h00;
        next_s.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (CE) begin
      s <= next_s;
    end
  end

  // card side outputs
  assign RDATA = s.rdata;
  assign CARD_ADDRESS = s.addr;
  assign CARD_DATA_OUT = s.wdata;
  assign CARD_DATA_OE_N = !(active && s.kind[0]);
  assign EVEN_BYTE_CARD_ENABLE_N = !(active && s.be[0]);
  assign ODD_BYTE_CARD_ENABLE_N = !(active && s.be[1]);
  assign OUTPUT_ENABLE_N = !(in_strobe && ((!s.kind[2] && !s.kind[0]) ||
                             (s.kind == pcs_pkg::PCS_K_DMA_IN && s.term_count)));
  assign WRITE_ENABLE_N = !(in_strobe && ((!s.kind[2] && s.kind[0]) ||
                            (s.kind == pcs_pkg::PCS_K_DMA_OUT && s.term_count)));
  assign IO_READ_STROBE_N = !(in_strobe && s.kind[2] && !s.kind[0]);
  assign IO_WRITE_STROBE_N = !(in_strobe && s.kind[2] && s.kind[0]);
  assign ATTRIBUTE_SELECT_N = !(active && (s.kind[2] || s.kind[1]));
  assign CARD_RESET = s.card_reset;

  // shared pins
  assign SOCKET_ACTIVITY = active;
  always_comb begin
    case (s.pin0_mode)
      pcs_pkg::PCS_PIN_OUT: GENERAL_PIN_0_OUT = s.gpo[0];
      pcs_pkg::PCS_PIN_LED: GENERAL_PIN_0_OUT = active;
      pcs_pkg::PCS_PIN_VIDEO: GENERAL_PIN_0_OUT = VIDEO_PORT_ENABLE_STATUS;
      default: GENERAL_PIN_0_OUT = 1'b0;
    endcase
    case (s.pin1_mode)
      pcs_pkg::PCS_PIN_OUT: GENERAL_PIN_1_OUT = s.gpo[1];
      pcs_pkg::PCS_PIN_LED: GENERAL_PIN_1_OUT = OTHER_SOCKET_ACTIVITY;
      default: GENERAL_PIN_1_OUT = 1'b0;
    endcase
  end
  assign GENERAL_PIN_0_OE_N = s.pin0_mode == pcs_pkg::PCS_PIN_IN;
  assign GENERAL_PIN_1_OE_N = !(s.pin1_mode == pcs_pkg::PCS_PIN_OUT ||
                                s.pin1_mode == pcs_pkg::PCS_PIN_LED);
  assign CARD_BINARY_AUDIO = card_audio;
  assign HOST_SPEAKER_OUT = s.speaker;
  assign CARD_STATUS_CHANGE_INTERRUPT = s.chg_flag;
  assign DMA_REQUEST = dma_req;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n || !CE);

  idle_strobes_a: assert property (
      !active |-> (IO_READ_STROBE_N && IO_WRITE_STROBE_N && OUTPUT_ENABLE_N && WRITE_ENABLE_N))
      else $error("strobe outside a cycle");
  io_read_a: assert property (
      (in_strobe && s.kind == pcs_pkg::PCS_K_IO_RD) |->
      (!IO_READ_STROBE_N && !ATTRIBUTE_SELECT_N && OUTPUT_ENABLE_N))
      else $error("io read strobes wrong");
  io_write_a: assert property (
      (in_strobe && s.kind == pcs_pkg::PCS_K_IO_WR) |-> (!IO_WRITE_STROBE_N && WRITE_ENABLE_N))
      else $error("io write strobes wrong");
  dma_count_a: assert property (
      (in_strobe && s.kind == pcs_pkg::PCS_K_DMA_IN) |-> (OUTPUT_ENABLE_N == !s.term_count))
      else $error("dma count on enable wrong");
  mem_write_a: assert property (
      (in_strobe && s.kind == pcs_pkg::PCS_K_MEM_WR) |->
      (!WRITE_ENABLE_N && ATTRIBUTE_SELECT_N)) else $error("memory write strobes wrong");
  dma_ack_a: assert property (
      (in_strobe && dma_cycle) |->
      (!ATTRIBUTE_SELECT_N && (IO_READ_STROBE_N != IO_WRITE_STROBE_N)))
      else $error("dma acknowledge missing");
  wait_hold_a: assert property (
      (in_strobe && s.cnt == 5'h00 && wait_active) |=> in_strobe)
      else $error("cycle ended under wait");
  strobe_len_a: assert property (
      $rose(in_strobe) |-> in_strobe [*8]) else $error("strobe too short");
  speaker_a: assert property (
      rst_n |=> HOST_SPEAKER_OUT == ($past(card_audio) ^ $past(OTHER_SOCKET_AUDIO)))
      else $error("speaker not xor");
  change_set_a: assert property (
      (s.chg_en && gp1_in != s.gp1_prev) |=> CARD_STATUS_CHANGE_INTERRUPT)
      else $error("pin change lost");
  even_byte_a: assert property (
      (in_strobe && !s.be[0]) |-> EVEN_BYTE_CARD_ENABLE_N)
      else $error("even enable without lane");
  odd_byte_a: assert property (
      (active && s.be[1]) |-> !ODD_BYTE_CARD_ENABLE_N)
      else $error("odd enable missing");
  led_pin_a: assert property (
      (s.pin1_mode == pcs_pkg::PCS_PIN_LED) |-> (GENERAL_PIN_1_OUT == OTHER_SOCKET_ACTIVITY))
      else $error("second activity pin wrong");
  keep_ctrl_a: assert property (disable iff (!CE)
      (!rst_n && suspend && !WSTB) |=> ctrl_word == $past(ctrl_word))
      else $error("registers lost in suspend");

  io_read_c: cover property (in_strobe && s.kind == pcs_pkg::PCS_K_IO_RD ##1 !in_strobe);
  dma_c: cover property (in_strobe && dma_cycle && s.term_count);
  wait_c: cover property (in_strobe && s.cnt == 5'h00 && wait_active ##1 in_strobe);
  change_c: cover property ($rose(CARD_STATUS_CHANGE_INTERRUPT));
endmodule // pcs_socket

// File: verif/pcs_card.sv
// behavioural 16-bit card standing on the far side of one socket
// assumes active-low strobes from the socket on the same clock
`timescale 1ns/100ps
module pcs_card (
  input wire logic clk,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [15:0] dout,
  input wire logic slow,
  input wire logic dreq,
  output logic [15:0] din,
  output logic wait_n,
  output logic ack_n
);
  logic [15:0] mem = 16'h5a3c;
  logic [15:0] drv = 16'h0000;
  logic [5:0] n = 6'h00;
  logic rd;
  logic wr;
  assign rd = !oe_n || !io_read_strobe_n;
  assign wr = !we_n || !io_write_strobe_n;
  assign din = drv;
  // stretch the strobe for 24 cycles when asked
  assign wait_n = !(slow && (rd || wr) && n < 6'h18);
  // answer io reads, or stand in as the dma request
  assign ack_n = !(!io_read_strobe_n || dreq);
  always @(posedge clk) begin
    // a released bus keeps no stale value
    drv <= rd ? mem : ~drv;
    n <= (rd || wr) ? n + 6'h1 : 6'h00;
    if (wr) begin
      mem <= dout;
    end
  end
endmodule // pcs_card

// File: verif/pc_card16_socket_signals_bench.sv
// self-checking bench for one card socket with a behavioural card
// assumes the socket block and pcs_card are compiled before it
`timescale 1ns/100ps
module pc_card16_socket_signals_bench;
  logic clk, rst_n, wstb, rstb, slow, dreq, oe_n, we_n, rd_n, wr_n, att_n, crst, doe_n, e_n;
  logic o_n, cd1, cd2, b1, b2, rdy, wt_n, wp, ack_n, g0i, g0o, g0e, g1i, g1o, g1e, x1, vid;
  logic susp_n, oact, oaud, act, aud, spk, irq, dma, vs1, vs2;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [25:0] ca;
  logic [15:0] din, dout;
  int n_mismatch = 0;
  int n_checks = 0;
  // pin level seen by both parties
  assign g0i = g0e ? 1'b0 : g0o;
  assign g1i = g1e ? x1 : g1o;

  pcs_socket DUT (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WSTB(wstb), .RSTB(rstb), .RDATA(rdata), .CARD_ADDRESS(ca), .CARD_DATA_IN(din),
    .CARD_DATA_OUT(dout), .CARD_DATA_OE_N(doe_n), .EVEN_BYTE_CARD_ENABLE_N(e_n),
    .ODD_BYTE_CARD_ENABLE_N(o_n), .OUTPUT_ENABLE_N(oe_n), .WRITE_ENABLE_N(we_n),
    .IO_READ_STROBE_N(rd_n), .IO_WRITE_STROBE_N(wr_n), .ATTRIBUTE_SELECT_N(att_n),
    .CARD_RESET(crst), .CARD_DETECT_FIRST_N(cd1), .CARD_DETECT_SECOND_N(cd2),
    .BATTERY_DETECT_FIRST(b1), .BATTERY_DETECT_SECOND(b2), .CARD_READY(rdy), .WAIT_N(wt_n),
    .WRITE_PROTECT(wp), .INPUT_ACKNOWLEDGE_N(ack_n), .VOLTAGE_SENSE_FIRST(vs1),
    .VOLTAGE_SENSE_SECOND(vs2), .GENERAL_PIN_0_IN(g0i), .GENERAL_PIN_0_OUT(g0o),
    .GENERAL_PIN_0_OE_N(g0e), .GENERAL_PIN_1_IN(g1i), .GENERAL_PIN_1_OUT(g1o),
    .GENERAL_PIN_1_OE_N(g1e), .VIDEO_PORT_ENABLE_STATUS(vid), .SUSPEND_N(susp_n),
    .OTHER_SOCKET_ACTIVITY(oact), .OTHER_SOCKET_AUDIO(oaud), .SOCKET_ACTIVITY(act),
    .CARD_BINARY_AUDIO(aud), .HOST_SPEAKER_OUT(spk), .CARD_STATUS_CHANGE_INTERRUPT(irq),
    .DMA_REQUEST(dma));
  pcs_card card (.clk(clk), .oe_n(oe_n), .we_n(we_n), .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n),
    .dout(dout), .slow(slow), .dreq(dreq), .din(din), .wait_n(wt_n), .ack_n(ack_n));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(pcs_pkg::PCS_REG_CTRL, d);
  endtask
  task automatic pause();
    repeat (4) @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_pins();
    rd(pcs_pkg::PCS_REG_CTRL);
    chk(v, 32'h0);
    chk({g0e, g1e, crst}, 3'h6);
    ctl(32'h2e);
    vid <= 1'b1;
    oact <= 1'b1;
    pause();
    chk({g0o, g0e, g1o, g1e, crst}, 5'h15);
    ctl(32'h94);
    vid <= 1'b0;
    oact <= 1'b0;
    pause();
    chk({g0o, g0e, g1o, g1e, crst}, 5'h04);
  endtask

  task automatic t_status();
    logic [1:0] bt;
    for (int i = 0; i < 8; i++) begin
      ctl(32'(i[2]));
      b1 <= i[1];
      b2 <= i[0];
      cd1 <= (i[1:0] == 2'h1); // detects grounded inside the card
      cd2 <= (i[1:0] == 2'h2);
      rdy <= i[0];
      wp <= i[1];
      vs1 <= i[0];
      vs2 <= i[1];
      oaud <= i[1];
      pause();
      rd(pcs_pkg::PCS_REG_STATUS);
      bt = !i[1] ? pcs_pkg::PCS_BATT_DEAD :
           (!i[0] ? pcs_pkg::PCS_BATT_WEAK : pcs_pkg::PCS_BATT_GOOD);
      chk(v[1], i[1:0] == 2'h0 || i[1:0] == 2'h3);
      chk({v[12:11], v[7]}, {i[1:0], i[1]});
      if (i[2]) begin
        chk({v[6], v[4]}, {i[0], i[1]});
        chk({aud, spk}, {i[0], i[0] ^ i[1]});
      end else begin
        chk({v[5], v[3:2]}, {i[0], bt});
        chk({aud, spk}, {1'b0, i[1]});
      end
    end
  endtask

  task automatic t_dma();
    logic [2:0] m;
    for (int i = 0; i < 6; i++) begin
      ctl(32'(i / 2) << pcs_pkg::PCS_CTRL_DSEL);
      m = 3'h1 << (i / 2);
      if (!i[0]) m = ~m;
      {wp, dreq, b2} <= m; // card drives the selected request line to i[0], the other two to its inverse
      pause();
      rd(pcs_pkg::PCS_REG_STATUS);
      chk({dma, v[10]}, {2{i[0]}});
    end
    dreq <= 1'b0;
  endtask

  task automatic t_chg();
    chk(irq, 1'b0);
    ctl(32'h100);
    x1 <= ~x1;
    pause();
    chk(irq, 1'b1);
    wr(pcs_pkg::PCS_REG_CLEAR, 32'h1);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    ctl(32'h0);
    x1 <= ~x1;
    pause();
    chk(irq, 1'b0);
  endtask

  task automatic cyc(input logic [5:0] cmd, output logic [9:0] s, output int len);
    int i;
    wr(pcs_pkg::PCS_REG_CMD, {26'h0, cmd});
    i = 0;
    len = 0;
    while ((oe_n & we_n & rd_n & wr_n) && i < 20) begin
      @(posedge clk);
      #1 i = i + 1;
    end
    s = {g0o, act, doe_n, att_n, o_n, e_n, wr_n, rd_n, we_n, oe_n};
    while (!(oe_n & we_n & rd_n & wr_n) && len < 60) begin
      @(posedge clk);
      #1 len = len + 1;
    end
    repeat (3) @(posedge clk);
    rd(pcs_pkg::PCS_REG_STATUS);
    chk(v[0], 1'b0);
  endtask

  task automatic t_kinds();
    logic [9:0] s;
    logic [2:0] k;
    logic [1:0] ln;
    logic tc, oe, we, ir, iw;
    int len;
    ctl(32'h8);
    wr(pcs_pkg::PCS_REG_ADDR, 32'hfe5a5a5b);
    wr(pcs_pkg::PCS_REG_WDATA, 32'h0000c3a5);
    #1 chk(ca, 26'h25a5a5b);
    for (int j = 0; j < 10; j++) begin
      k = (j < 8) ? 3'(j) : 3'(j - 2);
      tc = (j > 7);
      ln = 2'(j % 3 + 1);
      cyc({ln, tc, k}, s, len);
      oe = (k == 3'h0) || (k == 3'h2) || (k == 3'h6 && tc);
      we = (k == 3'h1) || (k == 3'h3) || (k == 3'h7 && tc);
      ir = (k == 3'h4) || (k == 3'h6);
      iw = (k == 3'h5) || (k == 3'h7);
      chk(s[3:0], {~iw, ~ir, ~we, ~oe});
      chk(s[7:4], {~k[0], ~(k > 3'h1), ~ln[1], ~ln[0]});
      chk(s[9:8], 2'h3);
      chk(len, pcs_pkg::PCS_STROBE_CYC);
      if (k == 3'h0 || k == 3'h2 || k == 3'h4) begin
        rd(pcs_pkg::PCS_REG_RDATA);
        chk(v, (j == 0) ? 32'h5a3c : 32'hc3a5);
        rd(pcs_pkg::PCS_REG_STATUS);
        if (k == 3'h4) chk(v[8], 1'b1);
      end
    end
  endtask

  task automatic t_wait();
    logic [9:0] s;
    int len;
    slow <= 1'b1;
    cyc({2'h3, 1'b0, pcs_pkg::PCS_K_IO_WR}, s, len);
    chk(len >= 24 && len <= 30, 1'b1);
    slow <= 1'b0;
  endtask

  task automatic t_susp();
    ctl(32'h2);
    susp_n <= 1'b0;
    pause();
    do_reset();
    rd(pcs_pkg::PCS_REG_CTRL);
    chk({v[15:0], crst}, {16'h2, 1'b1});
    susp_n <= 1'b1;
    pause();
    do_reset();
    rd(pcs_pkg::PCS_REG_CTRL);
    chk({v[15:0], crst}, 17'h0);
  endtask

  initial begin
    {rst_n, wstb, rstb, slow, dreq, b1, b2, rdy, wp, vs1, vs2, x1, vid, oact, oaud} = '0;
    {cd1, cd2, susp_n} = 3'h7;
    addr = 8'h00;
    wdata = 32'h0;
    do_reset();
    t_pins();
    t_status();
    t_dma();
    t_chg();
    t_kinds();
    t_wait();
    t_susp();
    end_of_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule // pc_card16_socket_signals_bench
